// File: shared/rlsc_pkg.sv
package rlsc_pkg;
  // Core clock and the integration step time.
  localparam int CLK_MHZ = 125;
  localparam int STEP_US = 2400;
  localparam int STEP_CYC = STEP_US * CLK_MHZ;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TIME = 8'h04;
  localparam logic [7:0] A_THR = 8'h08;
  localparam logic [7:0] A_PERS = 8'h0C;
  localparam logic [7:0] A_ISTAT = 8'h10;
  localparam logic [7:0] A_IMASK = 8'h14;
  localparam logic [7:0] A_ICLR = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1C;
  localparam logic [7:0] A_DATA = 8'h20;

  // Control register field positions.
  localparam int CTRL_EN = 0;
  localparam int CTRL_WEN = 1;
  localparam int CTRL_IEN = 2;
  localparam int CTRL_WLONG = 3;
  localparam int CTRL_GAIN = 4;

  // Sticky interrupt status bit positions.
  localparam int IS_DONE = 0;
  localparam int IS_THR = 1;

  // Values after reset.
  localparam logic [7:0] INTEG_STEP_SETTING_RST = 8'hFF;
  localparam logic [7:0] WTIME_RST = 8'hFF;
  localparam logic [15:0] THHI_RST = 16'hFFFF;

  // Per-step count limit and gain encodings.
  localparam logic [10:0] STEP_MAX = 11'h400;
  localparam logic [1:0] G4 = 2'h1;
  localparam logic [1:0] G16 = 2'h2;
  localparam logic [1:0] G60 = 2'h3;

  // Two-wire target address (arbitrary) and the clear command prefix.
  localparam logic [6:0] TWI_ADDR = 7'h3A;
  localparam logic [2:0] CMD_CLR = 3'h7;

  // Per-step counts of channels clear, red, green, blue (index 0..3).
  typedef struct packed {
    logic [3:0][10:0] ch;
  } rlsc_cnt_t;

  // Sixteen-bit results of the four channels, same order.
  typedef struct packed {
    logic [3:0][15:0] ch;
  } rlsc_res_t;
endpackage

// File: rtl/rlsc_sync.sv
`timescale 1ns/1ps
module rlsc_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rlsc_sync_t;

  rlsc_sync_t s;
  rlsc_sync_t n;

  // The first stage feeds only the second stage.
  always_comb begin
    n = s;
    n.s1 = d;
    n.s2 = s.s1;
  end

  // Two-flop synchroniser register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign q = s.s2;
endmodule

// File: rtl/rlsc_twi.sv
`timescale 1ns/1ps
module rlsc_twi (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic scl,
  input wire logic sda,
  input wire rlsc_pkg::rlsc_res_t res,
  output logic sda_oe,
  output logic clr
);
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_AACK, T_WR, T_WACK, T_RD, T_RACK} rlsc_tst_t;
  typedef struct packed {
    rlsc_tst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic [2:0] ptr;
    logic [63:0] snap;
    logic oe;
    logic clr;
    logic scl_q;
    logic sda_q;
  } rlsc_twi_t;

  rlsc_twi_t s;
  rlsc_twi_t n;
  logic rise;
  logic fall;
  logic [7:0] b;

  // Bus target: sample on rising clock, drive on falling clock.
  always_comb begin
    n = s;
    n.clr = 1'b0;
    n.scl_q = scl;
    n.sda_q = sda;
    rise = scl && !s.scl_q;
    fall = !scl && s.scl_q;
    b = s.snap[8*s.ptr +: 8];
    if (s.scl_q && scl && s.sda_q && !sda) begin
      n.st = T_ADDR;
      n.cnt = 4'h0;
      n.oe = 1'b0;
    end else if (s.scl_q && scl && !s.sda_q && sda) begin
      n.st = T_IDLE;
      n.oe = 1'b0;
    end else if (rise) begin
      if (s.st == T_ADDR || s.st == T_WR) begin
        n.sh = {s.sh[6:0], sda};
        n.cnt = s.cnt + 4'h1;
      end else if (s.st == T_RD) begin
        n.cnt = s.cnt + 4'h1;
      end else if (s.st == T_RACK) begin
        n.nack = sda;
      end
    end else if (fall) begin
      case (s.st)
        T_ADDR: begin
          if (s.cnt == 4'h8) begin
            if (s.sh[7:1] == rlsc_pkg::TWI_ADDR) begin
              n.oe = 1'b1;
              n.rw = s.sh[0];
              n.st = T_AACK;
              n.snap = res;
            end else begin
              n.st = T_IDLE;
            end
          end
        end
        T_WR: begin
          if (s.cnt == 4'h8) begin
            n.oe = 1'b1;
            n.st = T_WACK;
            if (s.sh[7:5] == rlsc_pkg::CMD_CLR) begin
              n.clr = 1'b1;
            end else begin
              n.ptr = s.sh[2:0];
            end
          end
        end
        T_AACK, T_RACK: begin
          if (s.st == T_AACK && !s.rw) begin
            n.oe = 1'b0;
            n.cnt = 4'h0;
            n.st = T_WR;
          end else if (s.st == T_RACK && s.nack) begin
            n.st = T_IDLE;
          end else begin
            n.oe = !b[7];
            n.sh = {b[6:0], 1'h0};
            n.ptr = s.ptr + 3'h1;
            n.cnt = 4'h0;
            n.st = T_RD;
          end
        end
        T_WACK: begin
          n.oe = 1'b0;
          n.cnt = 4'h0;
          n.st = T_WR;
        end
        T_RD: begin
          if (s.cnt == 4'h8) begin
            n.oe = 1'b0;
            n.st = T_RACK;
          end else begin
            n.oe = !s.sh[7];
            n.sh = {s.sh[6:0], 1'h0};
          end
        end
        default: n.st = T_IDLE;
      endcase
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign sda_oe = s.oe;
  assign clr = s.clr;
endmodule

// File: rtl/rlsc_core.sv
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module rlsc_core #(
  parameter int STEP_CYCLES = rlsc_pkg::STEP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire rlsc_pkg::rlsc_cnt_t step_cnt,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_o,
  output logic int_oe,
  output logic irq
);
  typedef enum logic [1:0] {S_IDLE, S_INTEG, S_WAIT} rlsc_fsm_t;
  typedef struct packed {
    rlsc_fsm_t st;
    logic [19:0] tick;
    logic [11:0] steps;
    logic [3:0][15:0] acc;
    rlsc_pkg::rlsc_res_t res;
    logic valid;
    logic aint;
    logic [3:0] pcnt;
    logic en;
    logic wen;
    logic ien;
    logic wlong;
    logic [1:0] gain;
    logic [7:0] integ_step_setting;
    logic [7:0] wtime;
    logic [15:0] thlo;
    logic [15:0] thhi;
    logic [3:0] pers;
    logic [1:0] istat;
    logic [1:0] imask;
    logic dph;
    logic dwr;
    logic [7:0] dad;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
    logic irq;
    logic int_oe;
    logic low;
  } rlsc_core_t;

  rlsc_core_t s;
  rlsc_core_t n;
  logic [1:0] pins;
  logic twi_clr;
  logic tdone;
  logic fin;
  logic go;
  logic out_rng;
  logic clr_any;
  logic [3:0] pc;
  logic [3:0] need;
  logic [11:0] wn;
  logic [11:0] wtot;
  logic [3:0][15:0] acc_new;

  // Scales one step's counts by the gain and caps them at one step's limit.
  function automatic logic [10:0] scale(input logic [10:0] c, input logic [1:0] g);
    logic [16:0] p;
    p = {6'h00, c};
    if (g == rlsc_pkg::G4) begin
      p = {4'h0, c, 2'h0};
    end else if (g == rlsc_pkg::G16) begin
      p = {2'h0, c, 4'h0};
    end else if (g == rlsc_pkg::G60) begin
      p = {c, 6'h00} - {4'h0, c, 2'h0};
    end
    return (p > {6'h00, rlsc_pkg::STEP_MAX}) ? rlsc_pkg::STEP_MAX : p[10:0];
  endfunction

  // Adds counts to a result and holds it at the top value.
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [10:0] c);
    logic [16:0] t;
    t = {1'h0, a} + {6'h00, c};
    return t[16] ? 16'hFFFF : t[15:0];
  endfunction

  // Read multiplexer over the register map; unmapped offsets read zero.
  function automatic logic [31:0] rd_word(input rlsc_core_t r, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == rlsc_pkg::A_CTRL) begin
      d[rlsc_pkg::CTRL_EN] = r.en;
      d[rlsc_pkg::CTRL_WEN] = r.wen;
      d[rlsc_pkg::CTRL_IEN] = r.ien;
      d[rlsc_pkg::CTRL_WLONG] = r.wlong;
      d[rlsc_pkg::CTRL_GAIN +: 2] = r.gain;
    end else if (a == rlsc_pkg::A_TIME) begin
      d[15:0] = {r.wtime, r.integ_step_setting};
    end else if (a == rlsc_pkg::A_THR) begin
      d = {r.thhi, r.thlo};
    end else if (a == rlsc_pkg::A_PERS) begin
      d[3:0] = r.pers;
    end else if (a == rlsc_pkg::A_ISTAT) begin
      d[1:0] = r.istat;
    end else if (a == rlsc_pkg::A_IMASK) begin
      d[1:0] = r.imask;
    end else if (a == rlsc_pkg::A_STAT) begin
      d[7:0] = {r.pcnt, r.st, r.aint, r.valid};
    end else if (a[7:4] == rlsc_pkg::A_DATA[7:4] && a[1:0] == 2'h0) begin
      d[15:0] = r.res.ch[a[3:2]];
    end
    return d;
  endfunction

  // Clock and data of the serial link are synchronised before use.
  rlsc_sync #(.W(2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .d({scl_i, sda_i}),
    .q(pins)
  );

  // Serial target that serves result reads and the interrupt clear command.
  rlsc_twi u_twi (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .scl(pins[1]),
    .sda(pins[0]),
    .res(s.res),
    .sda_oe(sda_oe),
    .clr(twi_clr)
  );

  // Register writes, bus reads, measurement sequencing and interrupt state.
  always_comb begin
    n = s;
    fin = 1'b0;
    go = 1'b0;
    out_rng = 1'b0;
    pc = 4'h0;
    acc_new = s.acc;
    tdone = (s.tick == 20'(STEP_CYCLES - 1));
    need = (s.pers == 4'h0) ? 4'h1 : s.pers;
    wn = 12'(9'h100 - {1'h0, s.wtime});
    wtot = s.wlong ? ((wn << 3) + (wn << 2)) : wn;
    clr_any = twi_clr;
    if (s.dph && s.dwr) begin
      if (s.dad == rlsc_pkg::A_CTRL) begin
        n.en = hwdata[rlsc_pkg::CTRL_EN];
        n.wen = hwdata[rlsc_pkg::CTRL_WEN];
        n.ien = hwdata[rlsc_pkg::CTRL_IEN];
        n.wlong = hwdata[rlsc_pkg::CTRL_WLONG];
        n.gain = hwdata[rlsc_pkg::CTRL_GAIN +: 2];
      end else if (s.dad == rlsc_pkg::A_TIME) begin
        n.integ_step_setting = hwdata[7:0];
        n.wtime = hwdata[15:8];
      end else if (s.dad == rlsc_pkg::A_THR) begin
        n.thlo = hwdata[15:0];
        n.thhi = hwdata[31:16];
      end else if (s.dad == rlsc_pkg::A_PERS) begin
        n.pers = hwdata[3:0];
      end else if (s.dad == rlsc_pkg::A_IMASK) begin
        n.imask = hwdata[1:0];
      end else if (s.dad == rlsc_pkg::A_ICLR) begin
        clr_any = clr_any || hwdata[0];
      end
    end
    if (clr_any) begin
      n.aint = 1'b0;
    end
    n.dph = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.dph = 1'b1;
      n.dwr = hwrite;
      n.dad = haddr[7:0];
      if (!hwrite) begin
        n.rdata = rd_word(n, haddr[7:0]);
        if (haddr[7:0] == rlsc_pkg::A_ISTAT) begin
          n.istat = 2'h0;
        end
      end
    end
    case (s.st)
      S_IDLE: begin
        go = n.en;
      end
      S_INTEG: begin
        if (!n.en) begin
          n.st = S_IDLE;
        end else if (tdone) begin
          n.tick = 20'h00000;
          for (int k = 0; k < 4; k++) begin
            acc_new[k] = sat_add(s.acc[k], scale(step_cnt.ch[k], s.gain));
          end
          n.acc = acc_new;
          if (s.steps == 12'h000) begin
            fin = 1'b1;
          end else begin
            n.steps = s.steps - 12'h001;
          end
        end else begin
          n.tick = s.tick + 20'h00001;
        end
      end
      S_WAIT: begin
        if (!n.en) begin
          n.st = S_IDLE;
        end else if (tdone) begin
          n.tick = 20'h00000;
          if (s.steps == 12'h000) begin
            go = 1'b1;
          end else begin
            n.steps = s.steps - 12'h001;
          end
        end else begin
          n.tick = s.tick + 20'h00001;
        end
      end
      default: n.st = S_IDLE;
    endcase
    if (fin) begin
      n.res.ch = acc_new;
      n.valid = 1'b1;
      n.istat[rlsc_pkg::IS_DONE] = 1'b1;
      out_rng = (acc_new[0] < s.thlo) || (acc_new[0] > s.thhi);
      if (out_rng) begin
        pc = (s.pcnt == 4'hF) ? s.pcnt : s.pcnt + 4'h1;
        n.pcnt = pc;
        if (pc >= need && s.ien) begin
          n.aint = 1'b1;
          n.istat[rlsc_pkg::IS_THR] = 1'b1;
        end
      end else begin
        n.pcnt = 4'h0;
      end
      if (s.wen) begin
        n.st = S_WAIT;
        n.steps = wtot - 12'h001;
      end else begin
        go = 1'b1;
      end
    end
    if (go) begin
      n.st = S_INTEG;
      n.tick = 20'h00000;
      n.steps = 12'(8'hFF - s.integ_step_setting);
      n.acc = '0;
    end
    n.irq = |(n.istat & n.imask);
    n.int_oe = n.aint && n.ien;
    n.low = 1'b0;
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.integ_step_setting <= rlsc_pkg::INTEG_STEP_SETTING_RST;
      s.wtime <= rlsc_pkg::WTIME_RST;
      s.thhi <= rlsc_pkg::THHI_RST;
      s.rdy <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  // Outputs come straight from the state register.
  assign hrdata = s.rdata;
  assign hreadyout = s.rdy;
  assign hresp = s.resp;
  assign sda_o = s.low;
  assign int_o = s.low;
  assign int_oe = s.int_oe;
  assign irq = s.irq;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence fin_s;
    ce && fin;
  endsequence

  sequence step_s;
    ce && s.st == S_INTEG && n.en && tdone;
  endsequence

  res_move_a: assert property (fin_s |=> s.res.ch == $past(acc_new))
    else $error("results not moved together");
  // With the wait off, the last step of a cycle restarts the sums, so only inner steps are watched here.
  chan_sum_a: assert property ((step_s and (s.steps != 12'h000))
    |=> s.acc[1] >= $past(s.acc[1]))
    else $error("channel accumulator wrapped");
  sat_top_a: assert property ((step_s and (s.acc[0] == 16'hFFFF && s.steps != 12'h000))
    |=> s.acc[0] == 16'hFFFF || s.st != S_INTEG)
    else $error("saturated result changed");
  step_len_a: assert property (s.tick <= 20'(STEP_CYCLES - 1))
    else $error("step counter past its length");
  wait_go_a: assert property ((fin_s and (s.en && s.wen)) |=> s.st == S_WAIT)
    else $error("wait interval not entered");
  thr_set_a: assert property ((fin_s and (out_rng && s.ien && need == 4'h1))
    |=> s.aint ##1 s.int_oe || !s.ien)
    else $error("out of range result did not interrupt");
  pers_rst_a: assert property ((fin_s and !out_rng) |=> s.pcnt == 4'h0)
    else $error("persistence count not restarted");
  int_hold_a: assert property (s.aint && ce && !clr_any |=> s.aint)
    else $error("interrupt released without clear");
  int_mask_a: assert property (s.int_oe |-> s.ien && s.aint)
    else $error("masked interrupt drives pin");
  od_pin_a: assert property (int_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain pin driven high");
endmodule

// File: tb/rlsc_host_model.sv
`timescale 1ns/1ps
module rlsc_host_model (
  input wire logic hclk,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  // Both lines start released, so the pull-ups show an idle bus.
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // A quarter bit is five core cycles, so the serial clock period is 160 ns.
  task half;
    repeat (5) @(posedge hclk);
  endtask

  // SDA falls while SCL is high, then SCL is pulled low.
  task start_c;
    sda_oe <= 1'b0;
    scl_oe <= 1'b0;
    half;
    half;
    sda_oe <= 1'b1;
    half;
    scl_oe <= 1'b1;
    half;
  endtask

  // SDA rises while SCL is high, which ends the frame and leaves SCL still.
  task stop_c;
    sda_oe <= 1'b1;
    half;
    scl_oe <= 1'b0;
    half;
    sda_oe <= 1'b0;
    half;
    half;
  endtask

  // SDA changes only while SCL is low and is sampled in the high phase.
  task bit_io(input logic b, output logic r);
    sda_oe <= !b;
    half;
    scl_oe <= 1'b0;
    half;
    r = sda;
    half;
    scl_oe <= 1'b1;
    half;
  endtask

  // Sends a byte most significant bit first; ack is low when the target answered.
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask

  // Reads a byte with SDA released, then answers ACK or NACK.
  task rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic hreadyout, hresp, sda_o, dut_sda, int_o, int_oe, irq;
  logic host_scl, host_sda, ack;
  logic [7:0] lo, hi;
  rlsc_pkg::rlsc_cnt_t step_cnt;
  int bad_count, checks;
  int cnt[4] = '{300, 10, 0, 700};
  // Open-drain lines with pull-ups: any party pulling low wins.
  wire scl = !host_scl;
  wire sda = !(host_sda | dut_sda);
  wire int_n = !int_oe;

  // Core clock of 8 ns.
  initial begin
    hclk = 1'b0;
    forever #4 hclk = !hclk;
  end

  rlsc_core #(.STEP_CYCLES(20)) DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .step_cnt(step_cnt), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(dut_sda),
    .int_o(int_o), .int_oe(int_oe), .irq(irq));
  rlsc_host_model u_host (.hclk(hclk), .sda(sda), .scl_oe(host_scl), .sda_oe(host_sda));

  // Prints the verdict and ends the run.
  task finish_test;
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for hready high at a rising edge, with a bound.
  task wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (n >= 100) begin
        bad_count++;
        $display("Error %0t: bus stalled", $time);
        finish_test;
      end
      n++;
      @(posedge hclk);
    end
  endtask

  // One single AHB-Lite word transfer; read data lands in rd.
  task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask

  // Waits for the interrupt request after letting a status clear settle.
  task wait_irq;
    int n;
    n = 0;
    repeat (3) @(posedge hclk);
    while (irq !== 1'b1) begin
      if (n >= 20000) begin
        bad_count++;
        $display("Error %0t: no interrupt", $time);
        finish_test;
      end
      n++;
      @(posedge hclk);
    end
  endtask

  // Expected result: per-step counts capped, summed over steps, saturated.
  function automatic int calc(int c, int mult, int steps);
    int p;
    p = c * mult;
    if (p > 1024) p = 1024;
    p = p * steps;
    return (p > 65535) ? 65535 : p;
  endfunction

  // Stops, programs timing, restarts and waits for the first completed result.
  task start_meas(input logic [31:0] ctrl, input logic [7:0] integ);
    ahb(rlsc_pkg::A_CTRL, 1'b1, 32'h00000000);
    ahb(rlsc_pkg::A_ISTAT, 1'b0, 32'h00000000);
    ahb(rlsc_pkg::A_TIME, 1'b1, {16'h0000, 8'hFF, integ});
    ahb(rlsc_pkg::A_IMASK, 1'b1, 32'h00000001);
    ahb(rlsc_pkg::A_CTRL, 1'b1, ctrl);
    wait_irq;
    ahb(rlsc_pkg::A_ISTAT, 1'b0, 32'h00000000);
    chk(rd & 32'h00000001, 32'h00000001);
  endtask

  // Values after reset and an unmapped place.
  task t_reset;
    ahb(rlsc_pkg::A_CTRL, 1'b0, 32'h00000000);
    chk(rd, 32'h00000000);
    ahb(rlsc_pkg::A_TIME, 1'b0, 32'h00000000);
    chk(rd, 32'h0000FFFF);
    ahb(rlsc_pkg::A_THR, 1'b0, 32'h00000000);
    chk(rd, 32'hFFFF0000);
    ahb(rlsc_pkg::A_PERS, 1'b0, 32'h00000000);
    chk(rd, 32'h00000000);
    ahb(8'h40, 1'b0, 32'h00000000);
    chk(rd, 32'h00000000);
    chk({hresp, int_n, irq}, 32'h00000002);
  endtask

  // Every gain at one step, then 66 steps at 4X so that two channels saturate early.
  task t_gain;
    int m[4];
    int gi;
    m = '{1, 4, 16, 60};
    for (int g = 0; g < 5; g++) begin
      gi = (g < 4) ? g : 1;
      start_meas({26'h0, 2'(gi), 4'h1}, (g < 4) ? 8'hFF : 8'hBE);
      for (int c = 0; c < 4; c++) begin
        ahb(rlsc_pkg::A_DATA + 8'(4 * c), 1'b0, 32'h00000000);
        chk(rd, calc(cnt[c], m[gi], (g < 4) ? 1 : 66));
      end
    end
  endtask

  // Out-of-range results with persistence two, enabled or masked.
  task t_thr(input logic ien);
    ahb(rlsc_pkg::A_CTRL, 1'b1, 32'h00000000);
    ahb(rlsc_pkg::A_ICLR, 1'b1, 32'h00000001);
    ahb(rlsc_pkg::A_PERS, 1'b1, 32'h00000002);
    ahb(rlsc_pkg::A_THR, 1'b1, 32'hFFFF1000);
    start_meas({29'h0, ien, 2'h1}, 8'hFF);
    chk(int_oe, 1'b0);
    wait_irq;
    ahb(rlsc_pkg::A_ISTAT, 1'b0, 32'h00000000);
    chk(int_oe, ien);
    ahb(rlsc_pkg::A_CTRL, 1'b1, {29'h0, ien, 2'h0});
    @(posedge hclk);
    chk({int_n, int_o}, {30'h0, !ien, 1'b0});
    ahb(rlsc_pkg::A_ICLR, 1'b1, 32'h00000001);
    @(posedge hclk);
    chk(int_oe, 1'b0);
  endtask

  // Long wait state, serial clear command, a coherent result read, and a foreign address.
  task t_serial;
    ahb(rlsc_pkg::A_PERS, 1'b1, 32'h00000000);
    start_meas(32'h0000000F, 8'hFF);
    ahb(rlsc_pkg::A_STAT, 1'b0, 32'h00000000);
    chk((rd >> 2) & 32'h00000003, 32'h00000002);
    ahb(rlsc_pkg::A_CTRL, 1'b1, 32'h00000004);
    chk(int_oe, 1'b1);
    u_host.start_c;
    u_host.wbyte({rlsc_pkg::TWI_ADDR, 1'b0}, ack);
    chk(ack, 1'b0);
    u_host.wbyte({rlsc_pkg::CMD_CLR, 5'h00}, ack);
    u_host.stop_c;
    repeat (10) @(posedge hclk);
    chk(int_oe, 1'b0);
    u_host.start_c;
    u_host.wbyte({rlsc_pkg::TWI_ADDR, 1'b0}, ack);
    u_host.wbyte(8'h00, ack);
    u_host.start_c;
    u_host.wbyte({rlsc_pkg::TWI_ADDR, 1'b1}, ack);
    u_host.rbyte(1'b0, lo);
    u_host.rbyte(1'b1, hi);
    u_host.stop_c;
    chk({hi, lo}, calc(cnt[0], 1, 1));
    u_host.start_c;
    u_host.wbyte({rlsc_pkg::TWI_ADDR ^ 7'h01, 1'b0}, ack);
    u_host.stop_c;
    chk(ack, 1'b1);
  endtask

  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    bad_count = 0;
    checks = 0;
    for (int c = 0; c < 4; c++) step_cnt.ch[c] = 11'(cnt[c]);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_gain;
    t_thr(1'b1);
    t_thr(1'b0);
    t_serial;
    finish_test;
  end
endmodule
